/* pkg/led_ctrl_pkg.sv */
package led_ctrl_pkg;

  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [7:0] ADDR_FUNCTION_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_GATE_SUPPLY_TARGET = 8'h01;
  localparam logic [7:0] ADDR_CH1_ON_VOLTAGE = 8'h20;
  localparam logic [7:0] ADDR_CH1_OFF_VOLTAGE = 8'h21;
  localparam logic [7:0] ADDR_CH2_ON_VOLTAGE = 8'h22;
  localparam logic [7:0] ADDR_CH2_OFF_VOLTAGE = 8'h23;

  // ************************************************************
  // function control fields
  // ************************************************************
  localparam int FC_SPI_STATUS_BIT = 7;
  localparam int FC_CLR_ERROR_BIT = 6;
  localparam int FC_CH2_ENABLE_BIT = 2;
  localparam int FC_CH1_ENABLE_BIT = 1;

  // ************************************************************
  // reset values and code limits
  // ************************************************************
  localparam logic [7:0] FUNCTION_CONTROL_RESET = 8'h00;
  localparam logic [7:0] GATE_SUPPLY_RESET = 8'ha6;
  localparam logic [7:0] VOLTAGE_RESET = 8'h00;
  localparam logic [7:0] GATE_SUPPLY_MIN_CODE = 8'h5d;
  localparam logic [7:0] GATE_SUPPLY_MAX_CODE = 8'ha6;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int MEAS_PERIOD_NS = 10000;
  localparam int MEAS_PERIOD_CYCLES = (MEAS_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MEAS_CNT_W = $clog2(MEAS_PERIOD_CYCLES);
  localparam int SPI_READY_NS = 1000;
  localparam int SPI_READY_CYCLES = (SPI_READY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int READY_CNT_W = $clog2(SPI_READY_CYCLES);
  localparam int STATIC_INTERVAL_US = 1000;
  localparam int STATIC_INTERVAL_CYCLES = STATIC_INTERVAL_US * 1000 / CLK_PERIOD_NS;

  // ************************************************************
  // device mode
  // ************************************************************
  typedef enum logic [2:0] {
    MODE_STARTUP = 3'b001,
    MODE_OPERATE = 3'b010,
    MODE_FAIL_SILENT = 3'b100
  } mode_t;

endpackage

/* rtl/pin_sync.sv */
`timescale 1ns/10ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;

  // two flops; only the second stage is visible to logic
  always_ff @(posedge clk) begin
    if (reset) begin
      stage1 <= '0;
      sync_out <= '0;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end

endmodule

/* rtl/channel_capture.sv */
`timescale 1ns/10ps
module channel_capture
  import led_ctrl_pkg::*;
#(
  parameter int STATIC_CYCLES = STATIC_INTERVAL_CYCLES
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic level,
  input wire logic sample_strobe,
  input wire logic [7:0] sample_code,
  input wire logic update_enable,
  output logic [7:0] on_voltage,
  output logic [7:0] off_voltage
);

  localparam int SW = $clog2(STATIC_CYCLES + 1);

  logic level_d;
  logic [7:0] latest_code;
  logic latest_level;
  logic latest_valid;
  logic [SW-1:0] static_cnt;
  logic level_edge;
  logic static_hit;

  assign level_edge = level ^ level_d;
  assign static_hit = (static_cnt == SW'(STATIC_CYCLES - 1));

  // remember the last sample with the dimming level seen when it was taken
  always_ff @(posedge clk) begin
    if (reset) begin
      level_d <= 1'b0;
      latest_code <= VOLTAGE_RESET;
      latest_level <= 1'b0;
      latest_valid <= 1'b0;
    end else begin
      level_d <= level;
      if (sample_strobe && update_enable) begin
        latest_code <= sample_code;
        latest_level <= level;
        latest_valid <= 1'b1;
      end
    end
  end

  // time since the last edge; wraps so a static input refreshes repeatedly
  always_ff @(posedge clk) begin
    if (reset || level_edge || static_hit) begin
      static_cnt <= '0;
    end else begin
      static_cnt <= static_cnt + SW'(1);
    end
  end

  // on an edge store into the register that matches the level of the sample; on a static hit store into both
  always_ff @(posedge clk) begin
    if (reset) begin
      on_voltage <= VOLTAGE_RESET;
      off_voltage <= VOLTAGE_RESET;
    end else if (latest_valid && update_enable) begin
      if (level_edge) begin
        if (latest_level) begin
          on_voltage <= latest_code;
        end else begin
          off_voltage <= latest_code;
        end
      end else if (static_hit) begin
        on_voltage <= latest_code;
        off_voltage <= latest_code;
      end
    end
  end

endmodule

/* rtl/led_channel_pwm_control.sv */
`timescale 1ns/10ps
module led_channel_pwm_control
  import led_ctrl_pkg::*;
#(
  parameter int STATIC_CYCLES = STATIC_INTERVAL_CYCLES
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic ch1_dimming_input,
  input wire logic ch2_dimming_input,
  input wire logic ch1_switch_request,
  input wire logic ch2_switch_request,
  input wire logic input_voltage_status,
  input wire logic bootstrap_undervoltage_error,
  input wire logic [7:0] ch1_adc_code,
  input wire logic [7:0] ch2_adc_code,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  output logic reg_error,
  output logic [1:0] gate_output,
  output logic [7:0] gate_supply_setting,
  output logic gate_supply_enable,
  output logic fail_silent,
  output logic meas_start
);

  // ************************************************************
  // declarations
  // ************************************************************
  mode_t mode;
  mode_t next_mode;
  logic [5:0] pins_sync;
  logic dim1;
  logic dim2;
  logic sw1;
  logic sw2;
  logic vin_ok;
  logic bsuv;
  logic ch1_input_enable;
  logic ch2_input_enable;
  logic spi_status_request;
  logic clr_error_pending;
  logic error_flag;
  logic error_event;
  logic [READY_CNT_W-1:0] ready_cnt;
  logic ready_done;
  logic [MEAS_CNT_W-1:0] meas_cnt;
  logic meas_tick;
  logic meas_enable;
  logic ch1_active;
  logic ch2_active;
  logic wr_fc;
  logic wr_gs;
  logic wr_ro;
  logic addr_mapped;
  logic addr_writable;
  logic [7:0] ch1_on_voltage;
  logic [7:0] ch1_off_voltage;
  logic [7:0] ch2_on_voltage;
  logic [7:0] ch2_off_voltage;
  logic [7:0] function_control_view;

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  // all pin status enters through one two-flop bank; the adc codes bypass it
  pin_sync #(
    .WIDTH(6)
  ) u_pin_sync (
    .clk(clk),
    .reset(reset),
    .async_in({bootstrap_undervoltage_error, input_voltage_status,
               ch2_switch_request, ch1_switch_request,
               ch2_dimming_input, ch1_dimming_input}),
    .sync_out(pins_sync)
  );

  // one dimming input per channel
  assign dim1 = pins_sync[0];
  assign dim2 = pins_sync[1];
  assign sw1 = pins_sync[2];
  assign sw2 = pins_sync[3];
  assign vin_ok = pins_sync[4];
  assign bsuv = pins_sync[5];

  // ************************************************************
  // register access decode
  // ************************************************************
  // writes land only on the two control registers; voltages are read only
  assign wr_fc = reg_write && (reg_addr == ADDR_FUNCTION_CONTROL);
  assign wr_gs = reg_write && (reg_addr == ADDR_GATE_SUPPLY_TARGET);

  // address classification for the error answer
  always_comb begin
    addr_mapped = 1'b0;
    addr_writable = 1'b0;
    case (reg_addr)
      ADDR_FUNCTION_CONTROL,
      ADDR_GATE_SUPPLY_TARGET: begin
        addr_mapped = 1'b1;
        addr_writable = 1'b1;
      end
      ADDR_CH1_ON_VOLTAGE,
      ADDR_CH1_OFF_VOLTAGE,
      ADDR_CH2_ON_VOLTAGE,
      ADDR_CH2_OFF_VOLTAGE: begin
        addr_mapped = 1'b1;
      end
      default: begin
        addr_mapped = 1'b0;
      end
    endcase
  end

  assign wr_ro = reg_write && !addr_writable;

  // ************************************************************
  // startup timer
  // ************************************************************
  // the serial interface is not declared usable until this expires or an error ends startup early
  always_ff @(posedge clk) begin
    if (reset) begin
      ready_cnt <= '0;
    end else if (!ready_done) begin
      ready_cnt <= ready_cnt + READY_CNT_W'(1);
    end
  end

  assign ready_done = (ready_cnt == READY_CNT_W'(SPI_READY_CYCLES - 1));

  // ************************************************************
  // function control register
  // ************************************************************
  // enable bits gate the dimming inputs; reserved bits are not stored
  always_ff @(posedge clk) begin
    if (reset) begin
      ch1_input_enable <= FUNCTION_CONTROL_RESET[FC_CH1_ENABLE_BIT];
      ch2_input_enable <= FUNCTION_CONTROL_RESET[FC_CH2_ENABLE_BIT];
      spi_status_request <= FUNCTION_CONTROL_RESET[FC_SPI_STATUS_BIT];
    end else if (wr_fc) begin
      ch1_input_enable <= reg_wdata[FC_CH1_ENABLE_BIT];
      ch2_input_enable <= reg_wdata[FC_CH2_ENABLE_BIT];
      spi_status_request <= reg_wdata[FC_SPI_STATUS_BIT];
    end
  end

  // ************************************************************
  // error clear request
  // ************************************************************
  // a pending request is consumed by the first error it sees, so an
  // error that arrives while the request waits is cleared at once
  always_ff @(posedge clk) begin
    if (reset) begin
      clr_error_pending <= FUNCTION_CONTROL_RESET[FC_CLR_ERROR_BIT];
    end else if (clr_error_pending && (error_flag || error_event)) begin
      clr_error_pending <= 1'b0;
    end else if (wr_fc && reg_wdata[FC_CLR_ERROR_BIT]) begin
      clr_error_pending <= 1'b1;
    end
  end

  // ************************************************************
  // error latch
  // ************************************************************
  // regulator codes above the maximum are treated as bootstrap undervoltage;
  // this may retrigger right after a clear until the code is fixed
  assign error_event = bsuv ||
                       (gate_supply_enable && (gate_supply_setting > GATE_SUPPLY_MAX_CODE));

  // the clear request wins over a new error, as the error is then
  // consumed together with the request
  always_ff @(posedge clk) begin
    if (reset) begin
      error_flag <= 1'b0;
    end else if (clr_error_pending && (error_flag || error_event)) begin
      error_flag <= 1'b0;
    end else if (error_event) begin
      error_flag <= 1'b1;
    end
  end

  // ************************************************************
  // device mode
  // ************************************************************
  // next mode from startup timer and error latch
  always_comb begin
    next_mode = mode;
    case (mode)
      MODE_STARTUP: begin
        if (error_flag) begin
          next_mode = MODE_FAIL_SILENT;
        end else if (ready_done) begin
          next_mode = MODE_OPERATE;
        end
      end
      MODE_OPERATE: begin
        if (error_flag) begin
          next_mode = MODE_FAIL_SILENT;
        end
      end
      MODE_FAIL_SILENT: begin
        if (!error_flag) begin
          next_mode = MODE_OPERATE;
        end
      end
      default: begin
        next_mode = MODE_STARTUP;
      end
    endcase
  end

  // mode register
  always_ff @(posedge clk) begin
    if (reset) begin
      mode <= MODE_STARTUP;
    end else begin
      mode <= next_mode;
    end
  end

  // fail-silent indication to the rest of the chip
  always_ff @(posedge clk) begin
    if (reset) begin
      fail_silent <= 1'b0;
    end else begin
      fail_silent <= (next_mode == MODE_FAIL_SILENT);
    end
  end

  // ************************************************************
  // gate supply target
  // ************************************************************
  // any code is stored as written so a read back shows what took effect;
  // the regulator maps it to its target, higher code lower voltage
  always_ff @(posedge clk) begin
    if (reset) begin
      gate_supply_setting <= GATE_SUPPLY_RESET;
    end else if (wr_gs) begin
      gate_supply_setting <= reg_wdata;
    end
  end

  // regulator off on low input voltage or while fail-silent
  always_ff @(posedge clk) begin
    if (reset) begin
      gate_supply_enable <= 1'b0;
    end else begin
      gate_supply_enable <= vin_ok && (next_mode != MODE_FAIL_SILENT);
    end
  end

  // ************************************************************
  // gate drivers
  // ************************************************************
  // a channel runs only with input high, enabled, supply good, operating
  assign ch1_active = dim1 && ch1_input_enable && vin_ok && (mode == MODE_OPERATE);
  assign ch2_active = dim2 && ch2_input_enable && vin_ok && (mode == MODE_OPERATE);

  // the hysteretic comparator request toggles the gate while active;
  // the two-flop sync adds latency to the comparator loop by design
  always_ff @(posedge clk) begin
    if (reset) begin
      gate_output <= 2'b00;
    end else begin
      gate_output[0] <= ch1_active && sw1;
      gate_output[1] <= ch2_active && sw2;
    end
  end

  // ************************************************************
  // measurement period
  // ************************************************************
  // free running period counter
  always_ff @(posedge clk) begin
    if (reset || meas_tick) begin
      meas_cnt <= '0;
    end else begin
      meas_cnt <= meas_cnt + MEAS_CNT_W'(1);
    end
  end

  assign meas_tick = (meas_cnt == MEAS_CNT_W'(MEAS_PERIOD_CYCLES - 1));
  assign meas_enable = vin_ok;

  // converter start pulse, one per period, suppressed on low input
  always_ff @(posedge clk) begin
    if (reset) begin
      meas_start <= 1'b0;
    end else begin
      meas_start <= meas_tick && meas_enable;
    end
  end

  // ************************************************************
  // per-channel capture
  // ************************************************************
  channel_capture #(
    .STATIC_CYCLES(STATIC_CYCLES)
  ) u_capture_ch1 (
    .clk(clk),
    .reset(reset),
    .level(dim1),
    .sample_strobe(meas_tick),
    .sample_code(ch1_adc_code),
    .update_enable(meas_enable),
    .on_voltage(ch1_on_voltage),
    .off_voltage(ch1_off_voltage)
  );

  channel_capture #(
    .STATIC_CYCLES(STATIC_CYCLES)
  ) u_capture_ch2 (
    .clk(clk),
    .reset(reset),
    .level(dim2),
    .sample_strobe(meas_tick),
    .sample_code(ch2_adc_code),
    .update_enable(meas_enable),
    .on_voltage(ch2_on_voltage),
    .off_voltage(ch2_off_voltage)
  );

  // ************************************************************
  // read back
  // ************************************************************
  // status bit needs the request and a finished startup; reserved read 0
  always_comb begin
    function_control_view = 8'h00;
    function_control_view[FC_SPI_STATUS_BIT] = spi_status_request &&
                                               (mode != MODE_STARTUP);
    function_control_view[FC_CLR_ERROR_BIT] = clr_error_pending;
    function_control_view[FC_CH2_ENABLE_BIT] = ch2_input_enable;
    function_control_view[FC_CH1_ENABLE_BIT] = ch1_input_enable;
  end

  // registered read data; voltage codes pass as stored
  always_ff @(posedge clk) begin
    if (reset) begin
      reg_rdata <= 8'h00;
    end else if (reg_read) begin
      case (reg_addr)
        ADDR_FUNCTION_CONTROL: reg_rdata <= function_control_view;
        ADDR_GATE_SUPPLY_TARGET: reg_rdata <= gate_supply_setting;
        ADDR_CH1_ON_VOLTAGE: reg_rdata <= ch1_on_voltage;
        ADDR_CH1_OFF_VOLTAGE: reg_rdata <= ch1_off_voltage;
        ADDR_CH2_ON_VOLTAGE: reg_rdata <= ch2_on_voltage;
        ADDR_CH2_OFF_VOLTAGE: reg_rdata <= ch2_off_voltage;
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  // read answer strobe and access error, both one-cycle pulses
  always_ff @(posedge clk) begin
    if (reset) begin
      reg_rvalid <= 1'b0;
      reg_error <= 1'b0;
    end else begin
      reg_rvalid <= reg_read;
      reg_error <= (reg_read && !addr_mapped) || wr_ro;
    end
  end

endmodule

/* tb/led_pwm_properties.sv */
`timescale 1ns/10ps
// ****
// port checks
// ****
module led_pwm_properties
  import led_ctrl_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic ch1_dimming_input,
  input wire logic ch2_dimming_input,
  input wire logic ch1_switch_request,
  input wire logic input_voltage_status,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic reg_error,
  input wire logic [1:0] gate_output,
  input wire logic [7:0] gate_supply_setting,
  input wire logic gate_supply_enable,
  input wire logic fail_silent,
  input wire logic meas_start
);
  int age;
  int gap;
  logic seen;
  logic fc_rd;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // cycles since release, capped so it never wraps
  always_ff @(posedge clk) begin
    age <= reset ? 0 : (age < 1000 ? age + 1 : age);
  end
  // spacing of pulses; the first pulse has no reference
  always_ff @(posedge clk) begin
    gap <= (reset || meas_start) ? 0 : gap + 1;
    seen <= !reset && (seen || meas_start);
  end
  // marks the answer cycle of a function control read
  always_ff @(posedge clk) begin
    fc_rd <= reg_read && reg_addr == ADDR_FUNCTION_CONTROL;
  end
  property p_period;
    meas_start && seen |-> (gap + 1) % MEAS_PERIOD_CYCLES == 0;
  endproperty
  property p_startup;
    fc_rd && age < 90 |-> reg_rvalid && !reg_rdata[FC_SPI_STATUS_BIT];
  endproperty
  property p_gate_src;
    gate_output[0] |-> $past(ch1_dimming_input, 3) && $past(ch1_switch_request, 3);
  endproperty
  property p_low1;
    !ch1_dimming_input [*4] |=> !gate_output[0];
  endproperty
  property p_low2;
    !ch2_dimming_input [*4] |=> !gate_output[1];
  endproperty
  property p_vin;
    !input_voltage_status [*4] |=> gate_output == 2'b00 && !gate_supply_enable && !meas_start;
  endproperty
  // reset values must show even while reset is held
  property p_rst;
    disable iff (1'b0)
    reset |=> gate_output == 2'b00 && gate_supply_setting == GATE_SUPPLY_RESET && !fail_silent;
  endproperty
  property p_gate_wr;
    reg_write && reg_addr == ADDR_GATE_SUPPLY_TARGET |=> gate_supply_setting == $past(reg_wdata);
  endproperty
  property p_ro;
    reg_write && reg_addr[7:2] == 6'h08 |=> reg_error;
  endproperty
  property p_fs;
    fail_silent [*2] |-> gate_output == 2'b00;
  endproperty
  a_period: assert property (p_period) else $error("measurement spacing wrong");
  a_startup: assert property (p_startup) else $error("status bit early");
  a_gate_src: assert property (p_gate_src) else $error("gate on without cause");
  a_low1: assert property (p_low1) else $error("gate 1 on while low");
  a_low2: assert property (p_low2) else $error("gate 2 on while low");
  a_vin: assert property (p_vin) else $error("low input still active");
  a_rst: assert property (p_rst) else $error("reset values wrong");
  a_gate_wr: assert property (p_gate_wr) else $error("gate code not stored");
  a_ro: assert property (p_ro) else $error("read-only write accepted");
  a_fs: assert property (p_fs) else $error("gate on in fail silent");
  c_meas: cover property (meas_start);
  c_fs: cover property ($rose(fail_silent));
  c_err: cover property (reg_error);
  c_gate: cover property (gate_output[0]);
endmodule
bind led_channel_pwm_control led_pwm_properties chk (.clk, .reset, .ch1_dimming_input,
  .ch2_dimming_input, .ch1_switch_request, .input_voltage_status, .reg_write, .reg_read,
  .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid, .reg_error, .gate_output,
  .gate_supply_setting, .gate_supply_enable, .fail_silent, .meas_start);

/* tb/mcu_model.sv */
`timescale 1ns/10ps
// ****
// controller model
// ****
module mcu_model
  import led_ctrl_pkg::*;
(
  input wire logic clk,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic reg_error,
  output logic reg_write,
  output logic reg_read,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic [1:0] dim
);
  logic [7:0] rd_data;
  logic rd_err;
  // quiet bus at time zero
  initial begin
    reg_write = 1'b0;
    reg_read = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    dim = 2'b00;
  end
  // one strobe cycle; unused data lines flip so stale values never look valid
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) #1;
    reg_addr = a;
    reg_wdata = !w ? ~reg_wdata : (a == ADDR_FUNCTION_CONTROL ? d & 8'hc6 : d);
    reg_write = w;
    reg_read = !w;
    @(posedge clk) #1;
    reg_write = 1'b0;
    reg_read = 1'b0;
    rd_err = reg_error;
    rd_data = (reg_rvalid === 1'b1) ? reg_rdata : 8'hxx;
  endtask
  // request the interface, then poll until it reports ready
  task automatic bring_up();
    xfer(1'b1, ADDR_FUNCTION_CONTROL, 8'h80);
    for (int i = 0; i < 80; i++) begin
      xfer(1'b0, ADDR_FUNCTION_CONTROL, 8'h00);
      if (rd_data[FC_SPI_STATUS_BIT] === 1'b1) break;
    end
  endtask
  // only allowed codes go out, and each is read straight back
  task automatic set_gate(input logic [7:0] c);
    logic [7:0] k;
    k = (c < GATE_SUPPLY_MIN_CODE) ? GATE_SUPPLY_MIN_CODE : c;
    if (k > GATE_SUPPLY_MAX_CODE) k = GATE_SUPPLY_MAX_CODE;
    xfer(1'b1, ADDR_GATE_SUPPLY_TARGET, k);
    xfer(1'b0, ADDR_GATE_SUPPLY_TARGET, 8'h00);
  endtask
  task automatic pwm(input logic [1:0] d);
    @(posedge clk) #1;
    dim = d;
  endtask
endmodule

/* tb/led_channel_pwm_control_test.sv */
`timescale 1ns/10ps
module led_channel_pwm_control_test
  import led_ctrl_pkg::*;
;
  localparam int STATIC_N = 3000;
  typedef struct packed {logic w; logic [7:0] a; logic [7:0] d; logic [7:0] q; logic e;} row_t;
  logic clk;
  logic reset;
  logic [1:0] sw;
  logic vin;
  logic bsuv;
  logic [7:0] adc1;
  logic [7:0] adc2;
  logic [1:0] dim, gate_output;
  logic reg_write, reg_read, reg_rvalid, reg_error;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, gate_supply_setting;
  logic gate_supply_enable, fail_silent, meas_start;
  int err_total = 0;
  int checks_done = 0;
  int cyc = 0;
  // ****
  // register rows: reset values, refusals
  // ****
  row_t rows [9] = '{'{1'b0, 8'h01, 8'h00, GATE_SUPPLY_RESET, 1'b0},
    '{1'b0, 8'h20, 8'h00, 8'h00, 1'b0}, '{1'b0, 8'h21, 8'h00, 8'h00, 1'b0},
    '{1'b0, 8'h22, 8'h00, 8'h00, 1'b0}, '{1'b0, 8'h23, 8'h00, 8'h00, 1'b0},
    '{1'b0, 8'h00, 8'h00, 8'h00, 1'b0}, '{1'b1, 8'h22, 8'h5a, 8'h00, 1'b1},
    '{1'b0, 8'h22, 8'h00, 8'h00, 1'b0}, '{1'b0, 8'h05, 8'h00, 8'h00, 1'b1}};
  led_channel_pwm_control #(.STATIC_CYCLES(STATIC_N)) dut (.clk, .reset,
    .ch1_dimming_input(dim[0]), .ch2_dimming_input(dim[1]), .ch1_switch_request(sw[0]),
    .ch2_switch_request(sw[1]), .input_voltage_status(vin), .bootstrap_undervoltage_error(bsuv),
    .ch1_adc_code(adc1), .ch2_adc_code(adc2), .reg_write, .reg_read, .reg_addr, .reg_wdata,
    .reg_rdata, .reg_rvalid, .reg_error, .gate_output, .gate_supply_setting,
    .gate_supply_enable, .fail_silent, .meas_start);
  mcu_model mcu (.clk, .reg_rdata, .reg_rvalid, .reg_error, .reg_write, .reg_read,
    .reg_addr, .reg_wdata, .dim);
  always #5 clk = ~clk;
  // hang guard; the whole run needs roughly ten thousand cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    mcu.xfer(1'b0, a, 8'h00);
    chk("read data", e, mcu.rd_data);
  endtask
  task automatic wait_meas();
    for (int i = 0; i < 1100; i++) begin
      step(1);
      if (meas_start === 1'b1) break;
    end
    chk("meas_start", 8'h01, {7'h00, meas_start});
  endtask
  task automatic wait_fs(input logic v);
    for (int i = 0; i < 20; i++) begin
      step(1);
      if (fail_silent === v) break;
    end
    chk("fail_silent", {7'h00, v}, {7'h00, fail_silent});
  endtask
  // ****
  // main sequence
  // ****
  initial begin
    // pin stimulus starts from procedural values so every input stays steerable
    clk = 1'b0;
    reset = 1'b1;
    sw = 2'b00;
    vin = 1'b1;
    bsuv = 1'b0;
    adc1 = 8'h55;
    adc2 = 8'h33;
    step(2);
    reset = 1'b0;
    foreach (rows[i]) begin
      mcu.xfer(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w) chk("row data", rows[i].q, mcu.rd_data);
      chk("row error", {7'h00, rows[i].e}, {7'h00, mcu.rd_err});
    end
    $display("test registers finished");
    mcu.bring_up();
    chk("status", 8'h80, mcu.rd_data & 8'h80);
    mcu.xfer(1'b1, ADDR_FUNCTION_CONTROL, 8'h86);
    rd(ADDR_FUNCTION_CONTROL, 8'h86);
    mcu.set_gate(8'ha6);
    chk("gate code", 8'ha6, mcu.rd_data);
    mcu.set_gate(8'h5d);
    chk("gate code", 8'h5d, gate_supply_setting);
    $display("test bring up finished");
    sw = 2'b11;
    mcu.pwm(2'b01);
    step(5);
    chk("gate", 8'h01, {6'h00, gate_output});
    mcu.pwm(2'b10);
    step(5);
    chk("gate", 8'h02, {6'h00, gate_output});
    mcu.xfer(1'b1, ADDR_FUNCTION_CONTROL, 8'h82);
    step(5);
    chk("gate", 8'h00, {6'h00, gate_output});
    mcu.xfer(1'b1, ADDR_FUNCTION_CONTROL, 8'h86);
    mcu.pwm(2'b01);
    step(5);
    $display("test gate finished");
    wait_meas();
    adc1 = 8'h66;
    mcu.pwm(2'b00);
    step(6);
    rd(ADDR_CH1_ON_VOLTAGE, 8'h55);
    rd(ADDR_CH1_OFF_VOLTAGE, 8'h00);
    wait_meas();
    mcu.pwm(2'b01);
    step(6);
    rd(ADDR_CH1_OFF_VOLTAGE, 8'h66);
    adc1 = 8'h77;
    wait_meas();
    step(STATIC_N + 20);
    rd(ADDR_CH1_ON_VOLTAGE, 8'h77);
    rd(ADDR_CH1_OFF_VOLTAGE, 8'h77);
    rd(ADDR_CH2_OFF_VOLTAGE, 8'h33);
    $display("test capture finished");
    vin = 1'b0;
    adc1 = 8'h11;
    mcu.pwm(2'b00);
    step(STATIC_N + 1100);
    rd(ADDR_CH1_OFF_VOLTAGE, 8'h77);
    chk("regulator", 8'h00, {7'h00, gate_supply_enable});
    vin = 1'b1;
    $display("test input voltage finished");
    mcu.xfer(1'b1, ADDR_FUNCTION_CONTROL, 8'hc6);
    rd(ADDR_FUNCTION_CONTROL, 8'hc6);
    bsuv = 1'b1;
    step(1);
    bsuv = 1'b0;
    step(8);
    rd(ADDR_FUNCTION_CONTROL, 8'h86);
    chk("fail_silent", 8'h00, {7'h00, fail_silent});
    bsuv = 1'b1;
    wait_fs(1'b1);
    bsuv = 1'b0;
    step(8);
    chk("fail_silent", 8'h01, {7'h00, fail_silent});
    mcu.xfer(1'b1, ADDR_FUNCTION_CONTROL, 8'hc6);
    wait_fs(1'b0);
    rd(ADDR_FUNCTION_CONTROL, 8'h86);
    $display("test error clear finished");
    reset = 1'b1;
    step(2);
    reset = 1'b0;
    chk("gate code", GATE_SUPPLY_RESET, gate_supply_setting);
    rd(ADDR_CH1_ON_VOLTAGE, 8'h00);
    rd(ADDR_FUNCTION_CONTROL, 8'h00);
    $display("test second reset finished");
    print_verdict();
  end
endmodule
